// ===== design/triple_dac_serial_loader.sv
// Notes on behaviour
// - shift data in on each serial rising edge
// - shifting only while chip select is low
// - act on the word at chip select rise
// - reset presets first two codes, clears rest
// - three independent eight-bit code registers
// - sleep forces output zero, code kept
// - waking restores retained code, no reload
// - word msb first: spare, aux, sleeps, loads, data
// - each control bit acts independently
// - paused clock keeps partial word
// - reset drives aux output low
`include "dac_loader_defines.svh"
module triple_dac_serial_loader
   import dac_loader_pkg::*;
(
   // core
   input wire logic core_clk,
   input wire logic rst,
   // serial link
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   // converter codes
   output logic [7:0] first_analog_out,
   output logic [7:0] second_analog_out,
   output logic [7:0] third_analog_out,
   // auxiliary
   output logic aux_latched_out
);
   word_cross_if xfer ();

   serial_shifter u_shift (
      .sclk(sclk),
      .cs_n(cs_n),
      .din(din),
      .rst(rst),
      .xfer(xfer)
   );

   // toggle sync; word is sampled only after the toggle settles
   // a toggle rather than a pulse, so a cs high time shorter than a core
   // period is still seen; the cost is a fixed two-to-three cycle latency
   logic tog_s1;
   logic tog_s2;
   logic tog_s3;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         tog_s1 <= 1'b0;
         tog_s2 <= 1'b0;
         tog_s3 <= 1'b0;
      end else begin
         tog_s1 <= xfer.toggle;
         tog_s2 <= tog_s1;
         tog_s3 <= tog_s2;
      end
   end
   logic exec;
   assign exec = tog_s2 ^ tog_s3;

   // sleep is kept apart from the code so waking needs no reload
   code_type code [3];
   code_type next_code [3];
   logic [2:0] sleep;
   logic [2:0] next_sleep;
   logic aux;
   logic next_aux;
   logic [7:0] out_code [3];
   logic [7:0] next_out [3];
   logic next_aux_out;

   // limitation: a new command must not start before the previous one executes (~3 clocks)
   always_comb begin
      next_aux = aux;
      next_sleep = sleep;
      for (int i = 0; i < 3; i++) begin
         next_code[i] = code[i];
      end
      if (exec) begin
         for (int i = 0; i < 3; i++) begin
            if (xfer.word[`POS_LOAD_FIRST + i]) begin
               next_code[i] = xfer.word[7:0];
            end
            // sleep bits are rewritten by every command; a clear bit wakes
            next_sleep[i] = xfer.word[`POS_SLEEP_FIRST + i];
         end
         next_aux = xfer.word[`POS_AUX];
      end
      for (int i = 0; i < 3; i++) begin
         next_out[i] = next_sleep[i] ? `ZERO_CODE : next_code[i];
      end
      next_aux_out = next_aux;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         // third converter resets to zero, the other two to full scale
         code[0] <= `FULL_SCALE_CODE;
         code[1] <= `FULL_SCALE_CODE;
         code[2] <= `ZERO_CODE;
         sleep <= 3'h0;
         aux <= 1'b0;
         out_code[0] <= `FULL_SCALE_CODE;
         out_code[1] <= `FULL_SCALE_CODE;
         out_code[2] <= `ZERO_CODE;
         aux_latched_out <= 1'b0;
      end else begin
         code <= next_code;
         sleep <= next_sleep;
         aux <= next_aux;
         out_code <= next_out;
         aux_latched_out <= next_aux_out;
      end
   end

   assign first_analog_out = out_code[0];
   assign second_analog_out = out_code[1];
   assign third_analog_out = out_code[2];

   // the word is read only while exec is high; by then the link has been idle
   // for at least one core cycle, so every bit of it has settled
   sequence s_exec_sleep(int i);
      exec && xfer.word[`POS_SLEEP_FIRST + i];
   endsequence

   a_sleep_zero: assert property (@(posedge core_clk) disable iff (rst)
      s_exec_sleep(0) |=> first_analog_out == 8'h00)
      else $error("sleeping output not zero");
   a_code_kept: assert property (@(posedge core_clk) disable iff (rst)
      sleep[0] |-> code[0] == $past(code[0]) || $past(exec))
      else $error("code lost in sleep");
   a_wake_restore: assert property (@(posedge core_clk) disable iff (rst)
      !sleep[1] |-> second_analog_out == code[1])
      else $error("awake output differs from code");
   a_load_third: assert property (@(posedge core_clk) disable iff (rst)
      exec && xfer.word[`POS_LOAD_THIRD] |=> code[2] == $past(xfer.word[7:0]))
      else $error("third code not loaded");
   a_no_load: assert property (@(posedge core_clk) disable iff (rst)
      !exec |=> code[0] == $past(code[0]))
      else $error("code changed without command");
   a_aux_follow: assert property (@(posedge core_clk) disable iff (rst)
      exec |=> aux_latched_out == $past(xfer.word[`POS_AUX]))
      else $error("aux output not latched");

   // one toggle step must give exactly one command
   a_exec_pulse: assert property (@(posedge core_clk) disable iff (rst)
      exec |=> !exec)
      else $error("command executed twice");
   a_aux_hold: assert property (@(posedge core_clk) disable iff (rst)
      !exec |=> aux_latched_out == $past(aux_latched_out))
      else $error("aux output moved without command");
   a_word_steady: assert property (@(posedge core_clk) disable iff (rst)
      exec |-> $stable(xfer.word))
      else $error("word moving while read");

   // reset values, checked at the edge after reset is seen
   a_reset_aux: assert property (@(posedge core_clk)
      rst |=> aux_latched_out == 1'b0 && first_analog_out == 8'hFF)
      else $error("reset values wrong");
   a_reset_codes: assert property (@(posedge core_clk)
      rst |=> second_analog_out == 8'hFF && third_analog_out == 8'h00)
      else $error("reset output codes wrong");
   a_reset_state: assert property (@(posedge core_clk)
      rst |=> sleep == 3'h0 && code[0] == 8'hFF && code[1] == 8'hFF && code[2] == 8'h00)
      else $error("reset state wrong");

   // one copy of the converter checks per channel, so the three cannot
   // drift apart when one of them is edited
   for (genvar g = 0; g < 3; g++) begin : g_conv
      sequence s_load_cmd;
         exec && xfer.word[`POS_LOAD_FIRST + g];
      endsequence
      sequence s_no_load;
         exec && !xfer.word[`POS_LOAD_FIRST + g];
      endsequence

      sequence s_sleep_cmd;
         exec && xfer.word[`POS_SLEEP_FIRST + g];
      endsequence
      sequence s_wake_cmd;
         exec && !xfer.word[`POS_SLEEP_FIRST + g];
      endsequence
      sequence s_idle;
         !exec;
      endsequence

      // checks run one cycle after the cycle they sample, when the registered outputs have moved; a_out_match holds every cycle
      a_load_code: assert property (@(posedge core_clk) disable iff (rst)
         s_load_cmd |=> code[g] == $past(xfer.word[7:0]))
         else $error("code not loaded");
      a_load_skip: assert property (@(posedge core_clk) disable iff (rst)
         s_no_load |=> code[g] == $past(code[g]))
         else $error("unselected code changed");
      a_sleep_keep: assert property (@(posedge core_clk) disable iff (rst)
         s_sleep_cmd ##0 s_no_load |=> code[g] == $past(code[g]) && out_code[g] == 8'h00)
         else $error("sleep lost the code or left the output");
      a_sleep_state: assert property (@(posedge core_clk) disable iff (rst)
         s_sleep_cmd |=> sleep[g])
         else $error("sleep bit not taken");
      a_wake_show: assert property (@(posedge core_clk) disable iff (rst)
         s_wake_cmd |=> !sleep[g] && out_code[g] == code[g])
         else $error("woken output differs from code");
      a_hold_state: assert property (@(posedge core_clk) disable iff (rst)
         s_idle |=> code[g] == $past(code[g]) && sleep[g] == $past(sleep[g]))
         else $error("converter state moved without command");
      a_out_match: assert property (@(posedge core_clk) disable iff (rst)
         out_code[g] == (sleep[g] ? 8'h00 : code[g]))
         else $error("output does not follow code and sleep");
   end : g_conv
endmodule : triple_dac_serial_loader

// ===== design/dac_loader_defines.svh
`ifndef DAC_LOADER_DEFINES_SVH
`define DAC_LOADER_DEFINES_SVH
`define WORD_BITS 16
`define CODE_BITS 8
`define FULL_SCALE_CODE 8'hFF
`define ZERO_CODE 8'h00
`define POS_SPARE 15
`define POS_AUX 14
`define POS_SLEEP_THIRD 13
`define POS_SLEEP_SECOND 12
`define POS_SLEEP_FIRST 11
`define POS_LOAD_THIRD 10
`define POS_LOAD_SECOND 9
`define POS_LOAD_FIRST 8
`endif

// ===== design/dac_loader_pkg.sv
package dac_loader_pkg;
   typedef logic [15:0] word_type;
   typedef logic [7:0] code_type;
endpackage : dac_loader_pkg

// ===== design/word_cross_if.sv
interface word_cross_if;
   logic [15:0] word;
   logic toggle;
   modport link (output word, output toggle);
   modport core (input word, input toggle);
endinterface : word_cross_if

// ===== design/serial_shifter.sv
`include "dac_loader_defines.svh"
module serial_shifter
   import dac_loader_pkg::*;
(
   // link side
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   input wire logic rst,
   // word to the core domain
   word_cross_if.link xfer
);
   word_type shift;
   word_type next_shift;

   // shifting is gated by chip select; no edge means contents hold across pauses
   always_comb begin
      next_shift = shift;
      if (!cs_n) begin
         next_shift = {shift[14:0], din};
      end
   end

   always_ff @(posedge sclk or posedge rst) begin
      if (rst) begin
         shift <= 16'h0000;
      end else begin
         shift <= next_shift;
      end
   end

   // the word is stable from the last clock until cs rises, so its release is safe
   assign xfer.word = shift;

   logic tog;
   always_ff @(posedge cs_n or posedge rst) begin
      if (rst) begin
         tog <= 1'b0;
      end else begin
         tog <= ~tog;
      end
   end
   assign xfer.toggle = tog;

   a_shift_pauses: assert property (@(posedge sclk) disable iff (rst)
      cs_n |=> shift == $past(shift))
      else $error("shift register moved while deselected");
   a_shift_samples: assert property (@(posedge sclk) disable iff (rst)
      !cs_n |=> shift[0] == $past(din))
      else $error("serial bit not sampled");
endmodule : serial_shifter

// ===== test/serial_host.sv
module serial_host (
   // serial pins
   output logic sclk = 1'b0,
   output logic cs_n = 1'b1,
   output logic din = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   // clocks out the low n bits of v msb first; sclk stands still between frames
   task automatic send(input logic [15:0] v, input int n, input bit p);
      cs_n = 1'b0;
      #150;
      for (int i = n - 1; i >= 0; i--) begin
         din = v[i];
         #15 sclk = 1'b1;
         #15 sclk = 1'b0;
         if (p && i == 8) #300;
      end
      #150 cs_n = 1'b1;
      // released data line must not keep its last value
      din = ~din;
      #250;
   endtask : send
   // clocks with chip select high; the device must ignore them
   task automatic stray(input logic [15:0] v);
      for (int i = 15; i >= 0; i--) begin
         din = v[i];
         #15 sclk = 1'b1;
         #15 sclk = 1'b0;
      end
      #250;
   endtask : stray
endmodule : serial_host

// ===== test/triple_dac_serial_loader_bench.sv
module triple_dac_serial_loader_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   wire logic sclk, cs_n, din;
   logic [7:0] o1, o2, o3;
   logic ao;
   int seed = 33674;
   int n_errors = 0;
   int num_checks = 0;
   logic [7:0] code [3];
   logic [2:0] slp;
   logic aux;
   logic [15:0] sh;
   logic [15:0] w;
   logic [24:0] want;
   always #12.5 core_clk = ~core_clk;
   serial_host host_i (.sclk(sclk), .cs_n(cs_n), .din(din));
   triple_dac_serial_loader triple_dac_serial_loader_i (.core_clk(core_clk), .rst(rst),
      .sclk(sclk), .cs_n(cs_n), .din(din), .first_analog_out(o1),
      .second_analog_out(o2), .third_analog_out(o3), .aux_latched_out(ao));
   task automatic test_done;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : test_done
   task automatic check;
      want = {aux, slp[0] ? 8'h00 : code[0], slp[1] ? 8'h00 : code[1],
         slp[2] ? 8'h00 : code[2]};
      num_checks++;
      if ({ao, o1, o2, o3} !== want) begin
         n_errors++;
         $display("wrong value at %0t: got %h want %h", $time, {ao, o1, o2, o3}, want);
      end
   endtask : check
   task automatic do_reset;
      rst <= 1'b1;
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      code = '{8'hFF, 8'hFF, 8'h00};
      slp = 3'h0;
      aux = 1'b0;
      sh = 16'h0000;
      repeat (2) @(posedge core_clk);
      check;
   endtask : do_reset
   // the shift register keeps old bits, so a short word mixes old and new
   task automatic run(input logic [15:0] v, input int n, input bit p);
      host_i.send(v, n, p);
      sh = (sh << n) | (v & 16'((17'h1 << n) - 1));
      for (int j = 0; j < 3; j++) begin
         if (sh[8 + j]) code[j] = sh[7:0];
         slp[j] = sh[11 + j];
      end
      aux = sh[14];
      repeat (8) @(posedge core_clk);
      check;
   endtask : run
   initial begin
      do_reset;
      $display("reset test done");
      for (int i = 0; i < 24; i++) begin
         w = 16'($random(seed));
         w[10:8] = 3'(i);
         run(w, 16, 1'b0);
      end
      $display("random word test done");
      run(16'h47A5, 16, 1'b1);
      $display("paused word test done");
      run(16'h0003, 5, 1'b0);
      $display("short word test done");
      host_i.stray(16'($random(seed)));
      repeat (2) @(posedge core_clk);
      check;
      $display("stray clock test done");
      do_reset;
      $display("second reset test done");
      test_done;
   end
   initial begin
      #200000;
      n_errors++;
      test_done;
   end
endmodule : triple_dac_serial_loader_bench
